// ### verilog/fspr_pkg.sv
// Package with register map, fields, reset values and command codes.
package fspr_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_FLASH_CONFIG = 8'hb1;
	localparam logic [7:0] ADDR_FLASH_COMMAND = 8'hb2;
	localparam logic [7:0] ADDR_FLASH_ADDR_LOW = 8'hb3;
	localparam logic [7:0] ADDR_FLASH_ADDR_HIGH = 8'hb4;
	localparam logic [7:0] ADDR_FLASH_DATA_MAILBOX = 8'hb5;
	localparam logic [7:0] ADDR_FLASH_STATUS = 8'hb6;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CFG_SHOW_BIT = 7;
	localparam int CFG_SPE_BIT = 6;
	localparam int CMD_IRQ_BIT = 7;
	localparam int ST_BUSY_BIT = 3;
	localparam int ST_FBUSY_BIT = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ----------------------------------------
	// Command codes of the op code field
	// ----------------------------------------
	localparam logic [6:0] OP_CHIP_ERASE = 7'h01;
	localparam logic [6:0] OP_BURST_PROG = 7'h06;
	localparam logic [6:0] OP_SECTOR_ERASE = 7'h0b;
	localparam logic [6:0] OP_BYTE_VERIFY = 7'h0c;
	localparam logic [6:0] OP_BLOCK_ERASE = 7'h0d;
	localparam logic [6:0] OP_BYTE_PROG = 7'h0e;

	// ----------------------------------------
	// Remap window
	// ----------------------------------------
	localparam logic [15:0] REMAP_BASE = 16'hf000;
	localparam logic [3:0] UPPER_NIBBLE = 4'hf;

	// Decoded operation sent to the flash array
	typedef enum logic [2:0] {
		FSPR_OP_NONE = 3'h0,
		FSPR_OP_CHIP = 3'h1,
		FSPR_OP_SECTOR = 3'h2,
		FSPR_OP_BLOCK = 3'h3,
		FSPR_OP_BURST = 3'h4,
		FSPR_OP_VERIFY = 3'h5,
		FSPR_OP_PROG = 3'h6
	} fspr_op_t;

	// Request towards the flash array
	typedef struct packed {
		fspr_op_t op;
		logic [15:0] addr;
		logic [7:0] data;
	} fspr_req_t;

endpackage

// ### verilog/fspr_remap.sv
// Program fetch address remapping and secondary block visibility.
`timescale 1ns/1ps
module fspr_remap (
	// Settings
	input wire logic [1:0] remap_sel,
	input wire logic upper_show,
	// Fetch address
	input wire logic [15:0] fetch_addr,
	output logic [15:0] mapped_addr,
	output logic upper_hit
);
	// Size of remapped span in address bits below F000h
	logic [15:0] span_mask;
	logic in_span;

	// Span: 00 off, 01 1 KB, 10 2 KB, 11 4 KB
	assign span_mask = (remap_sel == 2'h1) ? 16'h03ff :
		(remap_sel == 2'h2) ? 16'h07ff : 16'h0fff; // R7
	assign in_span = (remap_sel != 2'h0) &&
		((fetch_addr & ~span_mask) == 16'h0000); // R7
	assign mapped_addr = in_span ?
		(fspr_pkg::REMAP_BASE | fetch_addr) : fetch_addr; // R7
	// Secondary block responds only when shown
	assign upper_hit = upper_show &&
		(mapped_addr[15:12] == fspr_pkg::UPPER_NIBBLE); // R4
endmodule

// ### verilog/fspr_regs.sv
// Self-programming register front end of the embedded flash.
//
// Behaviour
// (R1) Status read-only: lock bits high, bits 4 and 1-0 zero
// (R2) Bit 3 busy until next burst byte
// (R3) Bit 2 busy until command fully done
// (R4) Config bit 7 shows upper block
// (R5) Config bit 6 gates flash commands
// (R6) Remap bits loaded from nonvolatile at reset
// (R7) Remap select redirects low 1/2/4 KB
// (R8) Command bit 7 steers interrupt 1
// (R9) Decode chip, sector, block erase
// (R10) Decode burst, verify, byte program
// (R11) Reserved codes start no operation
// (R12) Verify one cycle, never interrupts
// (R13) Data mailbox: write byte, verify result
// (R14) Low address mailbox gives bits 7-0
// (R15) High address mailbox gives bits 15-8
// (R16) Software loads mailboxes, waits before next
// (R17) Command sets busy; done clears, interrupts
`timescale 1ns/1ps
module fspr_regs (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Nonvolatile settings
	input wire logic [1:0] nv_remap_bits,
	input wire logic [2:0] security_lock_bits,
	// Flash array side
	output fspr_pkg::fspr_req_t flash_req,
	output logic flash_req_valid,
	input wire logic flash_byte_ready,
	input wire logic flash_done,
	input wire logic [7:0] flash_rdata,
	// Program fetch remap
	input wire logic [15:0] fetch_addr,
	output logic [15:0] mapped_addr,
	output logic upper_hit,
	// External interrupt 1
	input wire logic ext_irq1_pin,
	output logic irq1_out_n
);

	// ----------------------------------------
	// Operation state
	// ----------------------------------------
	typedef enum logic [1:0] {
		FSPR_IDLE = 2'b00,
		FSPR_RUN = 2'b01,
		FSPR_BURST = 2'b11
	} fspr_state_t;

	fspr_state_t state;
	fspr_state_t next_state;

	// Register contents
	logic [7:0] flash_config;
	logic [7:0] flash_command;
	logic [7:0] flash_addr_low;
	logic [7:0] flash_addr_high;
	logic [7:0] flash_data_mailbox;
	// One-cycle verify pending flag
	logic verify_pend;
	// Completion strobe for the interrupt line
	logic done_pulse;
	// Delayed reset for remap load
	logic reset_seen;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic wr_cfg;
	logic wr_cmd;
	logic wr_al;
	logic wr_ah;
	logic wr_dt;
	logic [6:0] op_code_field;
	fspr_pkg::fspr_op_t dec_op;
	logic start_op;
	logic start_verify;
	logic burst_byte;
	logic busy_bit;
	logic fbusy_bit;
	logic self_program_enable;
	logic completion_irq_enable;
	logic [7:0] status_val;

	assign wr_cfg = sfr_wr && (sfr_addr == fspr_pkg::ADDR_FLASH_CONFIG);
	assign wr_cmd = sfr_wr && (sfr_addr == fspr_pkg::ADDR_FLASH_COMMAND);
	assign wr_al = sfr_wr && (sfr_addr == fspr_pkg::ADDR_FLASH_ADDR_LOW);
	assign wr_ah = sfr_wr && (sfr_addr == fspr_pkg::ADDR_FLASH_ADDR_HIGH);
	assign wr_dt = sfr_wr &&
		(sfr_addr == fspr_pkg::ADDR_FLASH_DATA_MAILBOX);
	assign op_code_field = sfr_wdata[6:0];
	assign self_program_enable = flash_config[fspr_pkg::CFG_SPE_BIT];
	assign completion_irq_enable = flash_command[fspr_pkg::CMD_IRQ_BIT];

	// Command code to operation
	always_comb begin
		case (op_code_field)
			fspr_pkg::OP_CHIP_ERASE: dec_op = fspr_pkg::FSPR_OP_CHIP; // R9
			fspr_pkg::OP_SECTOR_ERASE: dec_op = fspr_pkg::FSPR_OP_SECTOR; // R9
			fspr_pkg::OP_BLOCK_ERASE: dec_op = fspr_pkg::FSPR_OP_BLOCK; // R9
			fspr_pkg::OP_BURST_PROG: dec_op = fspr_pkg::FSPR_OP_BURST; // R10
			fspr_pkg::OP_BYTE_VERIFY: dec_op = fspr_pkg::FSPR_OP_VERIFY; // R10
			fspr_pkg::OP_BYTE_PROG: dec_op = fspr_pkg::FSPR_OP_PROG; // R10
			// Reserved codes
			default: dec_op = fspr_pkg::FSPR_OP_NONE; // R11
		endcase
	end

	// Accept only when enabled, defined, and controller ready
	// A burst waiting for its next byte is not a free controller
	assign start_op = wr_cmd && self_program_enable &&
		(dec_op != fspr_pkg::FSPR_OP_NONE) && !fbusy_bit; // R5 R11 R17
	assign start_verify = start_op &&
		(dec_op == fspr_pkg::FSPR_OP_VERIFY);
	// Data mailbox write that hands the next burst byte to the array
	assign burst_byte = wr_dt && (state == FSPR_BURST) &&
		flash_byte_ready; // R2

	// Busy flags from state
	assign busy_bit = (state == FSPR_RUN) ||
		((state == FSPR_BURST) && !flash_byte_ready) || verify_pend; // R2
	assign fbusy_bit = (state != FSPR_IDLE) || verify_pend; // R3

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	assign status_val = {security_lock_bits, 1'b0, busy_bit, fbusy_bit,
		2'b00}; // R1

	always_comb begin
		sfr_rdata = fspr_pkg::RST_BYTE;
		if (sfr_rd) begin
			case (sfr_addr)
				fspr_pkg::ADDR_FLASH_CONFIG: sfr_rdata = flash_config;
				fspr_pkg::ADDR_FLASH_COMMAND: sfr_rdata = flash_command;
				fspr_pkg::ADDR_FLASH_ADDR_LOW: sfr_rdata = flash_addr_low;
				fspr_pkg::ADDR_FLASH_ADDR_HIGH: sfr_rdata = flash_addr_high;
				fspr_pkg::ADDR_FLASH_DATA_MAILBOX: begin
					sfr_rdata = flash_data_mailbox;
				end
				fspr_pkg::ADDR_FLASH_STATUS: sfr_rdata = status_val; // R1
				// Other addresses read zero
				default: sfr_rdata = fspr_pkg::RST_BYTE;
			endcase
		end
	end

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			FSPR_IDLE: begin
				// Verify does not occupy the sequencer
				if (start_op && !start_verify) begin
					next_state = (dec_op == fspr_pkg::FSPR_OP_BURST) ?
						FSPR_BURST : FSPR_RUN; // R17
				end
			end
			FSPR_RUN: begin
				if (flash_done) begin
					next_state = FSPR_IDLE; // R17
				end
			end
			FSPR_BURST: begin
				// Burst ends when the array reports the sequence done
				if (flash_done) begin
					next_state = FSPR_IDLE; // R3
				end
			end
			default: next_state = FSPR_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state <= FSPR_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Completion strobe, verify excluded
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			done_pulse <= 1'b0;
		end else begin
			done_pulse <= (state != FSPR_IDLE) && flash_done; // R12 R17
		end
	end

	// Verify takes one cycle
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			verify_pend <= 1'b0;
		end else begin
			verify_pend <= start_verify; // R12
		end
	end

	// ----------------------------------------
	// Request to flash array
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			flash_req <= '0;
			flash_req_valid <= 1'b0;
		end else begin
			flash_req_valid <= start_op || burst_byte;
			if (start_op) begin
				flash_req.op <= dec_op;
				flash_req.addr <= {flash_addr_high, flash_addr_low}; // R14 R15
				flash_req.data <= flash_data_mailbox; // R13
			end else if (burst_byte) begin
				// Next burst byte at current address
				flash_req.addr <= {flash_addr_high, flash_addr_low};
				flash_req.data <= sfr_wdata; // R13
			end
		end
	end

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			reset_seen <= 1'b0;
		end else begin
			reset_seen <= 1'b1;
		end
	end

	// Remap bits sampled in the first cycle after release
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			flash_config <= fspr_pkg::RST_BYTE;
		end else if (!reset_seen) begin
			flash_config[1:0] <= nv_remap_bits; // R6
		end else if (wr_cfg) begin
			flash_config <= {sfr_wdata[7:6], 4'h0, sfr_wdata[1:0]}; // R4 R5
		end
	end

	// Command register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			flash_command <= fspr_pkg::RST_BYTE;
		end else if (wr_cmd) begin
			flash_command <= sfr_wdata; // R8
		end
	end

	// Address and data mailboxes
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			flash_addr_low <= fspr_pkg::RST_BYTE;
			flash_addr_high <= fspr_pkg::RST_BYTE;
			flash_data_mailbox <= fspr_pkg::RST_BYTE;
		end else begin
			if (wr_al) begin
				flash_addr_low <= sfr_wdata; // R14
			end
			if (wr_ah) begin
				flash_addr_high <= sfr_wdata; // R15
			end
			if (verify_pend) begin
				flash_data_mailbox <= flash_rdata; // R13
			end else if (wr_dt) begin
				flash_data_mailbox <= sfr_wdata; // R13
			end
		end
	end

	// ----------------------------------------
	// Interrupt 1 steering
	// ----------------------------------------
	assign irq1_out_n = completion_irq_enable ?
		!done_pulse : ext_irq1_pin; // R8 R17

	// ----------------------------------------
	// Remap and visibility
	// ----------------------------------------
	fspr_remap u_remap (
		.remap_sel(flash_config[1:0]),
		.upper_show(flash_config[fspr_pkg::CFG_SHOW_BIT]),
		.fetch_addr(fetch_addr),
		.mapped_addr(mapped_addr),
		.upper_hit(upper_hit)
	);

endmodule

// ### dv/fspr_regs_chk.sv
// Assertion checker for the flash self-program register block.
`timescale 1ns/1ps
module fspr_regs_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic [2:0] security_lock_bits,
	// Flash side
	input wire fspr_pkg::fspr_req_t flash_req,
	input wire logic flash_req_valid,
	// Remap and interrupt
	input wire logic [15:0] fetch_addr,
	input wire logic [15:0] mapped_addr,
	input wire logic upper_hit,
	input wire logic ext_irq1_pin,
	input wire logic irq1_out_n
);
	// ----------------------------------------
	// Decodes
	// ----------------------------------------
	wire logic st_rd = sfr_rd && sfr_addr == 8'hb6;
	wire logic def_code = sfr_wdata[6:0] inside
		{7'h01, 7'h06, 7'h0b, 7'h0c, 7'h0d, 7'h0e};
	wire logic irq_low = ext_irq1_pin && !irq1_out_n;
	wire logic vfy = flash_req_valid &&
		flash_req.op == fspr_pkg::FSPR_OP_VERIFY;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	lock_bits_a: assert property (
		st_rd |-> sfr_rdata[7:5] == security_lock_bits &&
		sfr_rdata[4] == 1'h0 && sfr_rdata[1:0] == 2'h0)
		else $error("status fixed bits wrong");
	busy_nest_a: assert property (
		st_rd && sfr_rdata[3] |-> sfr_rdata[2])
		else $error("busy without flash busy");
	rsvd_cmd_a: assert property (
		sfr_wr && sfr_addr == 8'hb2 && !def_code |=> !flash_req_valid)
		else $error("reserved code started work");
	verify_fast_a: assert property (
		vfy ##1 st_rd |-> sfr_rdata[3:2] == 2'h0)
		else $error("verify still busy");
	verify_quiet_a: assert property (
		vfy |-> !irq_low [*3]) else $error("verify raised interrupt");
	irq_pulse_a: assert property (
		irq_low |=> !irq_low) else $error("completion pulse too long");
	remap_span_a: assert property (
		mapped_addr != fetch_addr |-> fetch_addr[15:12] == 4'h0 &&
		mapped_addr == {4'hf, fetch_addr[11:0]})
		else $error("remap outside low span");
	upper_hit_a: assert property (
		upper_hit |-> mapped_addr[15:12] == 4'hf)
		else $error("upper hit outside top block");
endmodule

bind fspr_regs fspr_regs_chk chk_i (.clk_sys(clk_sys), .reset_n(reset_n),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.security_lock_bits(security_lock_bits), .flash_req(flash_req),
	.flash_req_valid(flash_req_valid), .fetch_addr(fetch_addr),
	.mapped_addr(mapped_addr), .upper_hit(upper_hit),
	.ext_irq1_pin(ext_irq1_pin), .irq1_out_n(irq1_out_n));

// ### dv/test_flash_self_program_regs.sv
// Self-checking bench for the flash self-program register block.
`timescale 1ns/1ps
module test_flash_self_program_regs;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys = 1'h0;
	logic reset_n = 1'h0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'h0;
	logic sfr_rd = 1'h0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic [1:0] nv_remap_bits = 2'h2;
	logic [2:0] security_lock_bits = 3'h5;
	fspr_pkg::fspr_req_t flash_req;
	fspr_pkg::fspr_req_t got_req;
	logic flash_req_valid;
	logic flash_byte_ready = 1'h0;
	logic flash_done = 1'h0;
	logic [7:0] flash_rdata = 8'hc3;
	logic [15:0] fetch_addr = 16'h0000;
	logic [15:0] mapped_addr;
	logic upper_hit;
	logic ext_irq1_pin = 1'h1;
	logic irq1_out_n;
	int errors = 0;
	int cmp_count = 0;
	int irq_lows = 0;

	fspr_regs uut (.clk_sys(clk_sys), .reset_n(reset_n),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.nv_remap_bits(nv_remap_bits),
		.security_lock_bits(security_lock_bits), .flash_req(flash_req),
		.flash_req_valid(flash_req_valid),
		.flash_byte_ready(flash_byte_ready), .flash_done(flash_done),
		.flash_rdata(flash_rdata), .fetch_addr(fetch_addr),
		.mapped_addr(mapped_addr), .upper_hit(upper_hit),
		.ext_irq1_pin(ext_irq1_pin), .irq1_out_n(irq1_out_n));

	// Clock of 4 ns period
	always #2 clk_sys = ~clk_sys;

	// Count cycles of completion signalling on the interrupt line
	always @(negedge clk_sys) if (!irq1_out_n && ext_irq1_pin) irq_lows++;

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'h1;
		@(negedge clk_sys);
		sfr_wr = 1'h0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp, string name);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_rd = 1'h1;
		#1 chk(name, exp, sfr_rdata);
		// Hold the read across one rising edge so the checker sees it
		@(negedge clk_sys);
		sfr_rd = 1'h0;
	endtask
	// Wait a bounded time for a request pulse and keep its contents
	task automatic wait_req();
		int n;
		n = 0;
		while (flash_req_valid !== 1'h1 && n < 6) begin
			@(negedge clk_sys);
			n++;
		end
		got_req = flash_req;
		chk("request", 1, flash_req_valid);
	endtask
	task automatic no_req(string name);
		logic seen;
		// The pulse of a wrong request already stands on return of wr
		seen = flash_req_valid;
		repeat (5) begin
			@(negedge clk_sys);
			seen |= flash_req_valid;
		end
		chk(name, 0, seen);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(8'hb1, 8'h02, "config reset");
		rd(8'hb6, 8'ha0, "status reset");
		rd(8'hb3, 8'h00, "addr low reset");
		rd(8'hb4, 8'h00, "addr high reset");
		rd(8'hb7, 8'h00, "unmapped");
		wr(8'hb6, 8'hff);
		rd(8'hb6, 8'ha0, "status read only");
	endtask
	task automatic t_remap();
		for (int s = 0; s < 4; s++) begin
			wr(8'hb1, {6'h20, s[1:0]});
			for (int k = 1; k < 4; k++) begin
				fetch_addr = 16'(k) * 16'h0380;
				#1 chk("remap", (s >= k) ? {4'hf, fetch_addr[11:0]} :
					fetch_addr, mapped_addr);
			end
		end
		fetch_addr = 16'hf123;
		#1 chk("upper shown", 1, upper_hit);
		wr(8'hb1, 8'h00);
		chk("upper hidden", 0, upper_hit);
	endtask
	task automatic t_refuse();
		wr(8'hb1, 8'h40);
		wr(8'hb2, 8'h02);
		no_req("reserved code");
		wr(8'hb1, 8'h00);
		wr(8'hb2, 8'h0e);
		no_req("disabled");
		rd(8'hb2, 8'h0e, "command stored");
		ext_irq1_pin = 1'h0;
		#1 chk("irq pass low", 0, irq1_out_n);
		ext_irq1_pin = 1'h1;
		#1 chk("irq pass high", 1, irq1_out_n);
	endtask
	// One command with completion interrupt enabled
	task automatic do_op(logic [6:0] code, fspr_pkg::fspr_op_t op);
		logic v;
		v = op == fspr_pkg::FSPR_OP_VERIFY;
		wr(8'hb5, 8'h5a);
		irq_lows = 0;
		wr(8'hb2, {1'h1, code});
		wait_req();
		chk("op", op, got_req.op);
		chk("addr", 16'h12f4, got_req.addr);
		chk("data", 8'h5a, got_req.data);
		rd(8'hb6, v ? 8'ha0 : 8'hac, "status busy");
		if (op == fspr_pkg::FSPR_OP_BURST) begin
			flash_byte_ready = 1'h1;
			rd(8'hb6, 8'ha4, "byte ready");
			wr(8'hb5, 8'h77);
			wait_req();
			chk("burst data", 8'h77, got_req.data);
			flash_byte_ready = 1'h0;
		end
		if (!v) begin
			@(negedge clk_sys);
			flash_done = 1'h1;
			@(negedge clk_sys);
			flash_done = 1'h0;
		end
		repeat (3) @(negedge clk_sys);
		rd(8'hb6, 8'ha0, "status done");
		if (v) rd(8'hb5, 8'hc3, "verify byte");
		chk("irq cycles", v ? 0 : 1, irq_lows);
	endtask
	task automatic t_ops();
		logic [6:0] c [6] = '{7'h01, 7'h0b, 7'h0d, 7'h06, 7'h0e, 7'h0c};
		fspr_pkg::fspr_op_t o [6] = '{fspr_pkg::FSPR_OP_CHIP,
			fspr_pkg::FSPR_OP_SECTOR, fspr_pkg::FSPR_OP_BLOCK,
			fspr_pkg::FSPR_OP_BURST, fspr_pkg::FSPR_OP_PROG,
			fspr_pkg::FSPR_OP_VERIFY};
		wr(8'hb1, 8'h40);
		wr(8'hb4, 8'h12);
		wr(8'hb3, 8'hf4);
		for (int i = 0; i < 6; i++) do_op(c[i], o[i]);
	endtask
	// Second reset reloads the remap bits and clears the low address mailbox and the command register
	task automatic t_rereset();
		nv_remap_bits = 2'h1;
		@(negedge clk_sys);
		reset_n = 1'h0;
		repeat (2) @(negedge clk_sys);
		reset_n = 1'h1;
		repeat (2) @(negedge clk_sys);
		rd(8'hb1, 8'h01, "config re-reset");
		rd(8'hb3, 8'h00, "addr low re-reset");
		rd(8'hb2, 8'h00, "command re-reset");
	endtask

	// ----------------------------------------
	// Sequence, watchdog and verdict
	// ----------------------------------------
	task automatic conclude();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clk_sys);
		reset_n = 1'h1;
		repeat (2) @(negedge clk_sys);
		t_reset();
		t_remap();
		t_refuse();
		t_ops();
		t_rereset();
		conclude();
	end
	initial begin
		#40000;
		errors++;
		conclude();
	end
endmodule
